// ===== design/sdt_pkg.sv
// package: register map, field positions, reset values and encodings of the split dual timer
package sdt_pkg;
  localparam logic [5:0] OFS_CLK_EN   = 6'h00;
  localparam logic [5:0] OFS_OUT_EN   = 6'h01;
  localparam logic [5:0] OFS_OUT_VAL  = 6'h02;
  localparam logic [5:0] OFS_SPLIT    = 6'h03;
  localparam logic [5:0] OFS_CMD_CLR  = 6'h04;
  localparam logic [5:0] OFS_CMD_SET  = 6'h05;
  localparam logic [5:0] OFS_IRQ_EN   = 6'h0a;
  localparam logic [5:0] OFS_IRQ_ST   = 6'h0b;
  localparam logic [5:0] OFS_DBG      = 6'h0e;
  localparam logic [5:0] OFS_LOW_COUNTER_VALUE     = 6'h20;
  localparam logic [5:0] OFS_UCNT     = 6'h21;
  localparam logic [5:0] OFS_LOWER_PERIOD     = 6'h26;
  localparam logic [5:0] OFS_UPER     = 6'h27;
  localparam logic [5:0] OFS_CMP_BASE = 6'h28;
  localparam logic [5:0] OFS_CMP_LAST = 6'h2d;

  localparam int ENABLE_BIT   = 0;
  localparam int TICK_DIVIDER_SELECT_LSB   = 1;
  localparam int CMD_LSB      = 2;
  localparam int COMMAND_TARGET_SELECT_LSB    = 0;
  localparam int SPLIT_BIT    = 0;
  localparam int RUN_WHILE_HALTED_BIT   = 0;
  localparam int UPPER_LSB    = 4;
  localparam int FLAG_CMP_LSB = 4;
  localparam int FLAG_UUNF    = 1;
  localparam int FLAG_LOWER_UNDERFLOW_FLAG    = 0;

  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] CHAN_MASK  = 8'h77;
  localparam logic [7:0] FLAG_MASK  = 8'h73;
  localparam logic [7:0] COMMAND_TARGET_SELECT_MASK = 8'h03;
  localparam logic [7:0] CLK_MASK   = 8'h0f;

  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_RESTART = 2'h2;
  localparam logic [1:0] CMD_RESET   = 2'h3;
  localparam logic [1:0] COMMAND_TARGET_SELECT_BOTH  = 2'h3;

  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sdt_bus_t;

  typedef struct packed {
    logic [7:0] clk_en;
    logic [7:0] out_en;
    logic [7:0] out_val;
    logic [7:0] split;
    logic [7:0] cmd_target;
    logic [7:0] irq_en;
    logic [7:0] irq_st;
    logic [7:0] dbg;
    logic [7:0] lower_count;
    logic [7:0] upper_count;
    logic [7:0] lower_period;
    logic [7:0] upper_period;
    logic [7:0] lcmp0;
    logic [7:0] lcmp1;
    logic [7:0] lcmp2;
    logic [7:0] ucmp0;
    logic [7:0] ucmp1;
    logic [7:0] ucmp2;
    logic [9:0] presc;
    logic [5:0] wave;
    logic [5:0] pad_out;
    logic [5:0] pad_oe_n;
    logic [5:0] logic_out;
    logic [7:0] rdata;
    logic       irq;
  } sdt_state_t;
endpackage

// ===== design/sdt_timer.sv
// split dual 8-bit timer: registers, prescaler, two down-counters, flags and outputs
// Overview of operation
// - Tick is clock divided by 1,2,4,8,16,64,256,1024 for select codes 0..7.
// - Both counters run only while the enable bit is set.
// - Upper channel enable n drives waveform output n+3 instead of port value.
// - Lower channel enable n drives waveform output n instead of port value.
// - While disabled, software forces each waveform output through forced-value bits.
// - Forced values reach pads only when enabled; custom logic path bypasses enables.
// - Dual-byte select bit puts the timer into two 8-bit counters map.
// - Writing 1 to a command-clear bit clears that control bit.
// - Writing 1 to a command-set bit sets that control bit.
// - Command 0 none, 2 restart, 3 hard reset, 1 reserved; reads zero.
// - Hard reset command is ignored while the timer is enabled.
// - Command target 3 applies to both counters, 0 to none.
// - Irq enable: lower matches at bits 6..4, upper underflow 1, lower underflow 0.
// - Lower match flag n sets when lower count equals lower compare n.
// - Flags stay set until software writes 1 to them or a hard reset command clears them.
// - Upper underflow flag sets when upper count reaches zero.
// - Lower underflow flag sets when lower count reaches zero.
// - Run-while-halted 0 stops counting in debug break; 1 keeps running.
// - Software write to lower count wins over count, clear or reload.
// - Upper count is its own register; software writes win too.
// - Each counter has its own period register, reset 0xff, as top.
`timescale 1ns/1ns
module sdt_timer
  import sdt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire sdt_bus_t   bus,
  input  wire logic [5:0] addr_rd,
  input  wire logic       debug_halt,
  output logic      [7:0] rdata,
  output logic      [5:0] pad_out,
  output logic      [5:0] pad_oe_n,
  output logic      [5:0] logic_out,
  output logic            irq
);
  sdt_state_t q;
  sdt_state_t next_q;
  logic       halt_s1;
  logic       halt_s2;

  function automatic logic tick_due(input logic [2:0] sel, input logic [9:0] cnt);
    logic [9:0] m;
    begin
      case (sel)
        3'h0: m = 10'h000;
        3'h1: m = 10'h001;
        3'h2: m = 10'h003;
        3'h3: m = 10'h007;
        3'h4: m = 10'h00f;
        3'h5: m = 10'h03f;
        3'h6: m = 10'h0ff;
        default: m = 10'h3ff;
      endcase
      tick_due = (cnt & m) == m;
    end
  endfunction

  // register byte layout {6:4 upper, 2:0 lower} to channel layout {5:3 upper, 2:0 lower}
  function automatic logic [5:0] chan_pick(input logic [7:0] r);
    begin
      chan_pick = {r[UPPER_LSB +: 3], r[2:0]};
    end
  endfunction

  function automatic logic [7:0] reg_read(input sdt_state_t s, input logic [5:0] a);
    begin
      case (a)
        OFS_CLK_EN:  reg_read = s.clk_en;
        OFS_OUT_EN:  reg_read = s.out_en;
        OFS_OUT_VAL: reg_read = s.out_val;
        OFS_SPLIT:   reg_read = s.split;
        OFS_CMD_CLR,
        OFS_CMD_SET: reg_read = s.cmd_target;
        OFS_IRQ_EN:  reg_read = s.irq_en;
        OFS_IRQ_ST:  reg_read = s.irq_st;
        OFS_DBG:     reg_read = s.dbg;
        OFS_LOW_COUNTER_VALUE:    reg_read = s.lower_count;
        OFS_UCNT:    reg_read = s.upper_count;
        OFS_LOWER_PERIOD:    reg_read = s.lower_period;
        OFS_UPER:    reg_read = s.upper_period;
        6'h28:       reg_read = s.lcmp0;
        6'h29:       reg_read = s.ucmp0;
        6'h2a:       reg_read = s.lcmp1;
        6'h2b:       reg_read = s.ucmp1;
        6'h2c:       reg_read = s.lcmp2;
        OFS_CMP_LAST: reg_read = s.ucmp2;
        default:     reg_read = RST_ZERO;
      endcase
    end
  endfunction

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      halt_s1 <= 1'b0;
      halt_s2 <= 1'b0;
    end else if (ce) begin
      halt_s1 <= debug_halt;
      halt_s2 <= halt_s1;
    end
  end

  logic       en;
  logic       run;
  logic       tick;
  logic [1:0] cmd;
  logic [1:0] tgt;
  logic       both;
  logic       do_restart;
  logic       do_reset;
  logic [7:0] clr_mask;
  logic [7:0] set_flags;
  logic [2:0] cmp_hit;
  logic [5:0] oe;

  always_comb begin
    next_q     = q;
    en         = q.clk_en[ENABLE_BIT];
    run        = en && q.split[SPLIT_BIT] && (q.dbg[RUN_WHILE_HALTED_BIT] || !halt_s2);
    tick       = run && tick_due(q.clk_en[TICK_DIVIDER_SELECT_LSB +: 3], q.presc);
    cmd        = CMD_NONE;
    tgt        = q.cmd_target[COMMAND_TARGET_SELECT_LSB +: 2];
    clr_mask   = RST_ZERO;
    set_flags  = RST_ZERO;
    do_restart = 1'b0;
    do_reset   = 1'b0;
    next_q.presc = run ? q.presc + 10'h001 : 10'h000;

    if (bus.wr && bus.addr == OFS_CMD_SET) begin
      next_q.cmd_target = q.cmd_target | (bus.wdata & COMMAND_TARGET_SELECT_MASK);
      cmd = bus.wdata[CMD_LSB +: 2];
      tgt = q.cmd_target[COMMAND_TARGET_SELECT_LSB +: 2] | bus.wdata[COMMAND_TARGET_SELECT_LSB +: 2];
    end
    if (bus.wr && bus.addr == OFS_CMD_CLR) begin
      next_q.cmd_target = q.cmd_target & ~(bus.wdata & COMMAND_TARGET_SELECT_MASK);
      cmd = bus.wdata[CMD_LSB +: 2];
    end
    both       = tgt == COMMAND_TARGET_SELECT_BOTH;
    do_restart = both && cmd == CMD_RESTART;
    do_reset   = both && cmd == CMD_RESET && !en;

    // counting: reload to period after zero, else decrement
    if (tick) begin
      next_q.lower_count = (q.lower_count == RST_ZERO) ? q.lower_period
                                                        : q.lower_count - 8'h01;
      next_q.upper_count = (q.upper_count == RST_ZERO) ? q.upper_period
                                                        : q.upper_count - 8'h01;
    end
    if (do_restart) begin
      next_q.lower_count = q.lower_period;
      next_q.upper_count = q.upper_period;
      next_q.presc       = 10'h000;
      next_q.wave        = 6'h00;
    end

    // match and underflow events
    cmp_hit = {q.lower_count == q.lcmp2, q.lower_count == q.lcmp1,
               q.lower_count == q.lcmp0};
    if (tick) begin
      set_flags[FLAG_CMP_LSB +: 3] = cmp_hit[2:0];
      set_flags[FLAG_UUNF] = q.upper_count == RST_ZERO;
      set_flags[FLAG_LOWER_UNDERFLOW_FLAG] = q.lower_count == RST_ZERO;
      // pwm style: output high while count below compare
      for (int i = 0; i < 3; i++) begin
        next_q.wave[i]   = q.lower_count < (i == 0 ? q.lcmp0 : i == 1 ? q.lcmp1 : q.lcmp2);
        next_q.wave[i+3] = q.upper_count < (i == 0 ? q.ucmp0 : i == 1 ? q.ucmp1 : q.ucmp2);
      end
    end
    if (!en) begin
      next_q.wave = chan_pick(q.out_val);
    end

    // register writes: software wins over counting
    if (bus.wr) begin
      case (bus.addr)
        OFS_CLK_EN:  next_q.clk_en  = bus.wdata & CLK_MASK;
        OFS_OUT_EN:  next_q.out_en  = bus.wdata & CHAN_MASK;
        OFS_OUT_VAL: next_q.out_val = bus.wdata & CHAN_MASK;
        OFS_SPLIT:   next_q.split   = {7'h00, bus.wdata[SPLIT_BIT]};
        OFS_IRQ_EN:  next_q.irq_en  = bus.wdata & FLAG_MASK;
        OFS_IRQ_ST:  clr_mask       = bus.wdata & FLAG_MASK;
        OFS_DBG:     next_q.dbg     = {7'h00, bus.wdata[RUN_WHILE_HALTED_BIT]};
        OFS_LOW_COUNTER_VALUE:    next_q.lower_count = bus.wdata;
        OFS_UCNT:    next_q.upper_count = bus.wdata;
        OFS_LOWER_PERIOD:    next_q.lower_period = bus.wdata;
        OFS_UPER:    next_q.upper_period = bus.wdata;
        6'h28:       next_q.lcmp0 = bus.wdata;
        6'h29:       next_q.ucmp0 = bus.wdata;
        6'h2a:       next_q.lcmp1 = bus.wdata;
        6'h2b:       next_q.ucmp1 = bus.wdata;
        6'h2c:       next_q.lcmp2 = bus.wdata;
        OFS_CMP_LAST: next_q.ucmp2 = bus.wdata;
        default: ;
      endcase
    end
    next_q.irq_st = ((q.irq_st & ~clr_mask) | set_flags) & FLAG_MASK;

    if (do_reset) begin
      next_q.lower_count  = RST_ZERO;
      next_q.upper_count  = RST_ZERO;
      next_q.lower_period = RST_PERIOD;
      next_q.upper_period = RST_PERIOD;
      next_q.lcmp0 = RST_ZERO;
      next_q.lcmp1 = RST_ZERO;
      next_q.lcmp2 = RST_ZERO;
      next_q.ucmp0 = RST_ZERO;
      next_q.ucmp1 = RST_ZERO;
      next_q.ucmp2 = RST_ZERO;
      next_q.irq_st = RST_ZERO;
      next_q.presc  = 10'h000;
    end

    // gate with the enables that register together with the pads, so none leaks
    oe = chan_pick(next_q.out_en);
    next_q.pad_out   = next_q.wave & oe;
    next_q.pad_oe_n  = ~oe;
    next_q.logic_out = next_q.wave;
    next_q.rdata     = reg_read(next_q, addr_rd);
    next_q.irq       = |(next_q.irq_st & next_q.irq_en);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q              <= '0;
      q.lower_period <= RST_PERIOD;
      q.upper_period <= RST_PERIOD;
      q.pad_oe_n     <= 6'h3f;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign rdata     = q.rdata;
  assign pad_out   = q.pad_out;
  assign pad_oe_n  = q.pad_oe_n;
  assign logic_out = q.logic_out;
  assign irq       = q.irq;

  underflow_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && q.lower_count == 8'h00 && !do_reset |=> q.irq_st[0])
    else $error("lower underflow flag not set");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && q.irq_st[1] && !(bus.wr && bus.addr == 6'h0b && bus.wdata[1]) && !do_reset
    |=> q.irq_st[1])
    else $error("upper underflow flag dropped without write");
  stopped_count_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !q.clk_en[0] && !bus.wr |=> $stable(q.lower_count))
    else $error("counter moved while disabled");
  sw_write_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && bus.wr && bus.addr == 6'h20 && !do_reset |=> q.lower_count == $past(bus.wdata))
    else $error("lower count write lost");
  hard_reset_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && q.clk_en[0] && bus.wr && bus.addr == 6'h05 && bus.wdata == 8'h0f
    |=> q.lower_period == $past(q.lower_period))
    else $error("hard reset acted while enabled");
  irq_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> q.irq == |(q.irq_st & q.irq_en))
    else $error("interrupt does not match flags");
  div1_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && run && q.clk_en[3:1] == 3'h0 && !bus.wr && q.lower_count != 8'h00
    |=> q.lower_count == $past(q.lower_count) - 8'h01)
    else $error("divide-by-one count step wrong");
  pad_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> (q.pad_out & ~{q.out_en[6:4], q.out_en[2:0]}) == 6'h00)
    else $error("pad driven without enable");

  // rule checks on the registered state
  upper_underflow_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && q.upper_count == RST_ZERO
    |=> q.irq_st[FLAG_UUNF])
    else $error("upper underflow flag not set");

  lower_match0_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && q.lower_count == q.lcmp0
    |=> q.irq_st[FLAG_CMP_LSB])
    else $error("lower match flag 0 not set");

  lower_match1_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && q.lower_count == q.lcmp1
    |=> q.irq_st[FLAG_CMP_LSB + 1])
    else $error("lower match flag 1 not set");

  lower_match2_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && q.lower_count == q.lcmp2
    |=> q.irq_st[FLAG_CMP_LSB + 2])
    else $error("lower match flag 2 not set");

  lower_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && !bus.wr && q.lower_count == RST_ZERO
    |=> q.lower_count == $past(q.lower_period))
    else $error("lower count did not reload");

  upper_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && !bus.wr && q.upper_count == RST_ZERO
    |=> q.upper_count == $past(q.upper_period))
    else $error("upper count did not reload");

  upper_step_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && run && !bus.wr && q.clk_en[TICK_DIVIDER_SELECT_LSB +: 3] == 3'h0 && q.upper_count != RST_ZERO
    |=> q.upper_count == $past(q.upper_count) - 8'h01)
    else $error("upper count step wrong");

  upper_write_wins_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && bus.wr && bus.addr == OFS_UCNT
    |=> q.upper_count == $past(bus.wdata))
    else $error("upper count write lost");

  write_over_tick_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && tick && bus.wr && bus.addr == OFS_LOW_COUNTER_VALUE
    |=> q.lower_count == $past(bus.wdata))
    else $error("count step beat a lower count write");

  restart_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && do_restart
    |=> q.lower_count == $past(q.lower_period) && q.upper_count == $past(q.upper_period))
    else $error("restart did not load periods");

  hard_reset_clears_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && do_reset
    |=> q.lower_period == RST_PERIOD && q.upper_count == RST_ZERO && q.irq_st == RST_ZERO)
    else $error("hard reset left state behind");

  halt_freeze_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && halt_s2 && !q.dbg[RUN_WHILE_HALTED_BIT] && !bus.wr
    |=> $stable(q.lower_count) && $stable(q.upper_count))
    else $error("counter moved in debug halt");

  split_needed_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !q.split[SPLIT_BIT] && !bus.wr
    |=> $stable(q.upper_count))
    else $error("counter moved without dual-byte select");

  cmd_reads_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && (addr_rd == OFS_CMD_SET || addr_rd == OFS_CMD_CLR)
    |=> q.rdata[CMD_LSB +: 2] == CMD_NONE)
    else $error("command field read not zero");

  forced_wave_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !q.clk_en[ENABLE_BIT]
    |=> {1'b0, q.wave[5:3], 1'b0, q.wave[2:0]} == $past(q.out_val))
    else $error("forced value not on waveform");

  pad_value_a: assert property (@(posedge clk) disable iff (!rstn)
    ce
    |-> q.pad_out == (q.logic_out & ~q.pad_oe_n))
    else $error("pad value differs from waveform");

  div2_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && run && !bus.wr && tick && q.clk_en[TICK_DIVIDER_SELECT_LSB +: 3] == 3'h1
    |=> !tick)
    else $error("divide-by-two ticks too close");

  irq_en_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && bus.wr && bus.addr == OFS_IRQ_EN
    |=> q.irq_en == ($past(bus.wdata) & FLAG_MASK))
    else $error("irq enable write wrong");

  set_target_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && bus.wr && bus.addr == OFS_CMD_SET
    |=> (q.cmd_target & $past(bus.wdata) & COMMAND_TARGET_SELECT_MASK) == ($past(bus.wdata) & COMMAND_TARGET_SELECT_MASK))
    else $error("command target bit not set");

  clear_target_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && bus.wr && bus.addr == OFS_CMD_CLR
    |=> (q.cmd_target & $past(bus.wdata) & COMMAND_TARGET_SELECT_MASK) == RST_ZERO)
    else $error("command target bit not cleared");

  reserved_cmd_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !run && bus.wr && bus.addr == OFS_CMD_SET && bus.wdata[CMD_LSB +: 2] == 2'h1
    |=> $stable(q.lower_count) && $stable(q.lower_period))
    else $error("reserved command acted");

  no_target_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !run && bus.wr && bus.addr == OFS_CMD_SET
    && (q.cmd_target[COMMAND_TARGET_SELECT_LSB +: 2] | bus.wdata[COMMAND_TARGET_SELECT_LSB +: 2]) != COMMAND_TARGET_SELECT_BOTH
    |=> $stable(q.lower_count) && $stable(q.upper_count))
    else $error("command acted without both targets");

  clear_by_one_a: assert property (@(posedge clk) disable iff (!rstn)
    ce && !tick && bus.wr && bus.addr == OFS_IRQ_ST
    |=> (q.irq_st & $past(bus.wdata) & FLAG_MASK) == RST_ZERO)
    else $error("flag not cleared by one");
endmodule

// ===== testbench/sdt_timer_tb.sv
// self-checking bench for the split dual 8-bit timer
`timescale 1ns/1ns
module sdt_timer_tb;
  import sdt_pkg::*;
  logic        clk        = 1'b0;
  logic        rstn       = 1'b0;
  logic        ce         = 1'b1;
  sdt_bus_t    bus        = '0;
  logic [5:0]  addr_rd    = 6'h00;
  logic        debug_halt = 1'b0;
  logic [7:0]  rdata;
  logic [5:0]  pad_out;
  logic [5:0]  pad_oe_n;
  logic [5:0]  logic_out;
  logic        irq;
  logic [31:0] lfsr       = 32'hbe5bacdf;
  logic [7:0]  v;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  logic [5:0]  rw_ofs [8] = '{OFS_OUT_EN, OFS_OUT_VAL, OFS_IRQ_EN, OFS_DBG, OFS_LOW_COUNTER_VALUE, OFS_UCNT,
                              OFS_LOWER_PERIOD, OFS_CMP_LAST};
  logic [7:0]  rw_msk [8] = '{CHAN_MASK, CHAN_MASK, FLAG_MASK, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff};

  sdt_timer dut_u (.clk(clk), .rstn(rstn), .ce(ce), .bus(bus), .addr_rd(addr_rd),
    .debug_halt(debug_halt), .rdata(rdata), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .logic_out(logic_out), .irq(irq));

  always #4 clk = ~clk;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // register byte layout {6:4 upper, 2:0 lower} to output bit layout {5:3 upper, 2:0 lower}
  function automatic logic [7:0] chan6(input logic [7:0] r);
    return {2'b00, r[6:4], r[2:0]};
  endfunction

  function automatic logic [7:0] ticks(input int c);
    int d;
    d = (c < 5) ? (1 << c) : (c == 5 ? 64 : (c == 6 ? 256 : 1024));
    return 8'((4 * d + 3) / d);
  endfunction

  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic get(input logic [5:0] a);
    addr_rd <= a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    get(a);
    check(what, exp, v);
  endtask

  // counts with a prescaler phase that is not known to the bench: one tick either way
  task automatic near(input logic [5:0] a, input logic [7:0] exp, input string what);
    get(a);
    check(what, exp, (v >= exp - 8'd1 && v <= exp + 8'd1) ? exp : v);
  endtask

  task automatic outs(input logic [7:0] p, input logic [7:0] oe, input logic [7:0] lo);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("pad_out", p, {2'b00, pad_out});
    check("pad_oe_n", oe, {2'b00, pad_oe_n});
    check("logic_out", lo, {2'b00, logic_out});
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      rd(6'(i), (i == 6'h26 || i == 6'h27) ? RST_PERIOD : RST_ZERO, "reset value");
    end
    check("reset oe_n", 8'h3f, {2'b00, pad_oe_n});
    for (int i = 0; i < 16; i++) begin
      lfsr = next_rand(lfsr);
      wr(rw_ofs[i % 8], lfsr[7:0]);
      rd(rw_ofs[i % 8], lfsr[7:0] & rw_msk[i % 8], "register readback");
    end
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      wr(OFS_OUT_EN, lfsr[7:0]);
      wr(OFS_OUT_VAL, lfsr[15:8]);
      outs(chan6(lfsr[7:0] & lfsr[15:8]), ~chan6(lfsr[7:0]) & 8'h3f, chan6(lfsr[15:8]));
    end
    wr(OFS_LOW_COUNTER_VALUE, 8'h11);
    ce <= 1'b0;
    wr(OFS_LOW_COUNTER_VALUE, 8'h99);
    ce <= 1'b1;
    rd(OFS_LOW_COUNTER_VALUE, 8'h11, "write with ce low");
    wr(OFS_CMD_SET, 8'h01);
    rd(OFS_CMD_CLR, 8'h01, "target after set");
    wr(OFS_CMD_SET, 8'h02);
    rd(OFS_CMD_SET, 8'h03, "target after set");
    wr(OFS_CMD_CLR, 8'h01);
    rd(OFS_CMD_SET, 8'h02, "target after clear");
    wr(OFS_CMD_CLR, 8'h02);
    rd(OFS_CMD_SET, 8'h00, "target after clear");
    wr(OFS_LOWER_PERIOD, 8'h40);
    wr(OFS_UPER, 8'h30);
    wr(OFS_LOW_COUNTER_VALUE, 8'h05);
    wr(OFS_UCNT, 8'h06);
    wr(OFS_CMD_SET, 8'h08);
    rd(OFS_LOW_COUNTER_VALUE, 8'h05, "restart with no target");
    wr(OFS_CMD_SET, 8'h07);
    rd(OFS_LOW_COUNTER_VALUE, 8'h05, "reserved command");
    wr(OFS_CMD_SET, 8'h0b);
    rd(OFS_LOW_COUNTER_VALUE, 8'h40, "restart lower");
    rd(OFS_UCNT, 8'h30, "restart upper");
    rd(OFS_CMD_SET, 8'h03, "command reads zero");
    rd(OFS_LOWER_PERIOD, 8'h40, "restart keeps period");
    wr(OFS_LOW_COUNTER_VALUE, 8'h12);
    wr(OFS_CMD_CLR, 8'h08);
    rd(OFS_LOW_COUNTER_VALUE, 8'h40, "restart through clear port");
    wr(OFS_CLK_EN, 8'h0f);
    wr(OFS_CMD_SET, 8'h0f);
    rd(OFS_LOWER_PERIOD, 8'h40, "hard reset while enabled");
    rd(OFS_CLK_EN, 8'h0f, "clock select readback");
    wr(OFS_CLK_EN, 8'h00);
    wr(OFS_CMD_SET, 8'h0f);
    rd(OFS_LOWER_PERIOD, 8'hff, "hard reset period");
    rd(OFS_LOW_COUNTER_VALUE, 8'h00, "hard reset count");
    wr(OFS_LOW_COUNTER_VALUE, 8'h20);
    wr(OFS_CLK_EN, 8'h01);
    repeat (10) @(posedge clk);
    wr(OFS_CLK_EN, 8'h00);
    rd(OFS_LOW_COUNTER_VALUE, 8'h20, "count without split");
    wr(OFS_SPLIT, 8'h01);
    repeat (10) @(posedge clk);
    rd(OFS_LOW_COUNTER_VALUE, 8'h20, "count while disabled");
    for (int c = 0; c < 8; c++) begin
      wr(OFS_LOW_COUNTER_VALUE, 8'hf0);
      wr(OFS_CLK_EN, 8'({c[2:0], 1'b1}));
      repeat (4 * ((c < 5) ? (1 << c) : (c == 5 ? 64 : (c == 6 ? 256 : 1024)))) @(posedge clk);
      wr(OFS_CLK_EN, 8'h00);
      near(OFS_LOW_COUNTER_VALUE, 8'hf0 - ticks(c), "prescaled count");
    end
    debug_halt <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      wr(OFS_DBG, 8'(d));
      wr(OFS_LOW_COUNTER_VALUE, 8'hf0);
      wr(OFS_CLK_EN, 8'h01);
      repeat (20) @(posedge clk);
      wr(OFS_CLK_EN, 8'h00);
      get(OFS_LOW_COUNTER_VALUE);
      check("count in debug halt", 8'(d), {7'h00, v !== 8'hf0});
    end
    debug_halt <= 1'b0;
    wr(OFS_CLK_EN, 8'h01);
    wr(OFS_LOW_COUNTER_VALUE, 8'h55);
    wr(OFS_UCNT, 8'ha5);
    wr(OFS_CLK_EN, 8'h00);
    near(OFS_LOW_COUNTER_VALUE, 8'h50, "lower write priority");
    near(OFS_UCNT, 8'ha2, "upper write priority");
    wr(OFS_CMD_SET, 8'h0f);
    rd(OFS_IRQ_ST, 8'h00, "flags after hard reset");
    for (int i = 0; i < 6; i++) begin
      wr(OFS_LOWER_PERIOD + 6'(i), (i < 4) ? ((i < 2) ? 8'h03 : 8'h02) : 8'h00);
    end
    wr(OFS_CMP_BASE, 8'h01);
    wr(OFS_CMP_BASE + 6'h2, 8'h02);
    wr(OFS_CMP_BASE + 6'h4, 8'h80);
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_CLK_EN, 8'h01);
    repeat (6) @(posedge clk);
    wr(OFS_CLK_EN, 8'h00);
    rd(OFS_IRQ_ST, 8'h33, "flags after counting");
    get(OFS_LOW_COUNTER_VALUE);
    check("count within period", 8'h01, {7'h00, v <= 8'h03});
    repeat (20) @(posedge clk);
    rd(OFS_IRQ_ST, 8'h33, "flags held");
    check("irq on underflow", 8'h01, {7'h00, irq});
    wr(OFS_IRQ_ST, 8'h01);
    rd(OFS_IRQ_ST, 8'h32, "flag cleared by one");
    check("irq after clear", 8'h00, {7'h00, irq});
    wr(OFS_IRQ_EN, 8'h20);
    rd(OFS_IRQ_ST, 8'h32, "flags unchanged");
    check("irq on match", 8'h01, {7'h00, irq});
    wr(OFS_IRQ_ST, 8'hff);
    rd(OFS_IRQ_ST, 8'h00, "flags cleared");
    check("irq idle", 8'h00, {7'h00, irq});
    wr(OFS_LOWER_PERIOD, 8'h00);
    wr(OFS_UPER, 8'h00);
    wr(OFS_LOW_COUNTER_VALUE, 8'h00);
    wr(OFS_UCNT, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CMP_BASE + 6'(i), (i == 0) ? 8'h01 : (i == 3) ? 8'h07 : (i == 4) ? 8'h05 : 8'h00);
    end
    wr(OFS_OUT_EN, 8'h77);
    wr(OFS_CLK_EN, 8'h01);
    outs(8'h15, 8'h00, 8'h15);
    wr(OFS_OUT_EN, 8'h05);
    outs(8'h05, 8'h3a, 8'h15);
    wr(OFS_CLK_EN, 8'h00);
    report_and_stop();
  end
endmodule
